// ---- bench/bpsc_checker.sv ----
/* checker on the bridge power ports; bound to bpsc_bridge_power */
`timescale 1ns/1ps
module bpsc_checker #(parameter int NPORTS = 3) (
    // inputs
    input wire logic CLK_SYS, RST_B, TLP_VALID, TO_ACKS_DONE,
    input wire logic [NPORTS-1:0] CFG_DONE, PSF_WR, POWER_REMOVED, ERR_EVENT, ERR_FROM_TLP,
    input wire logic [2*NPORTS-1:0] PSF_WDATA,
    // outputs
    input wire logic [2*NPORTS-1:0] PSTATE,
    input wire logic [NPORTS-1:0] ERR_MSG,
    input wire logic SWITCH_LOW_POWER, TLP_ACCEPT, TLP_UR, TLP_UC, TLP_ROUTE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    wire [1:0] s0 = PSTATE[1:0];
    a_cfg_active: assert property (CFG_DONE[0] && s0 == 2'h0 |=> s0 == 2'h1)
        else $error("cfg");
    a_enter_d3: assert property (PSF_WR[0] && PSF_WDATA[1:0] == 2'h3 && s0 == 2'h1
        |=> s0 == 2'h2) else $error("d3");
    a_leave_d3: assert property (PSF_WR[0] && PSF_WDATA[1:0] == 2'h0 && s0 == 2'h2
        && !POWER_REMOVED[0] |=> s0 == 2'h0) else $error("d0");
    a_cold_entry: assert property (POWER_REMOVED[0] && s0 == 2'h2 |=> s0 == 2'h3)
        else $error("cold");
    a_one_answer: assert property (TLP_VALID |=>
        $onehot({TLP_ACCEPT, TLP_UR, TLP_UC, TLP_ROUTE})) else $error("tlp");
    a_err_kept: assert property (ERR_EVENT[0] && ERR_FROM_TLP[0] |=> ERR_MSG[0])
        else $error("err");
    a_err_drop: assert property (ERR_EVENT[0] && !ERR_FROM_TLP[0] && s0 == 2'h2
        |=> !ERR_MSG[0]) else $error("drop");
    a_switch_low: assert property (s0 == 2'h2 && TO_ACKS_DONE |=> SWITCH_LOW_POWER)
        else $error("low");
endmodule
bind bpsc_bridge_power bpsc_checker #(.NPORTS(NPORTS)) i_bpsc_checker (.*);

// ---- bench/bpsc_host.sv ----
/* software model: one-cycle power events; clock from the bench */
`timescale 1ns/1ps
module bpsc_host (
    input wire logic CLK_SYS,
    output logic [2:0] CFG_DONE, PSF_WR, POWER_REMOVED,
    output logic [5:0] PSF_WDATA
);
    initial {CFG_DONE, PSF_WR, POWER_REMOVED, PSF_WDATA} = '0;
    task automatic ev(input logic [2:0] c, w, p, input logic [5:0] d);
        @(posedge CLK_SYS);
        CFG_DONE <= c;
        PSF_WR <= w;
        POWER_REMOVED <= p;
        PSF_WDATA <= d;
        @(posedge CLK_SYS);
        {CFG_DONE, PSF_WR, POWER_REMOVED} <= '0;
        PSF_WDATA <= ~d;
    endtask
endmodule

// ---- bench/test_bridge_power_state_control.sv ----
/* self-checking bench; host model drives power events, bench drives tlps */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR %0t %h %h", $time, a, e); end end
module test_bridge_power_state_control;
    import bpsc_pkg::*;
    logic CLK_SYS = 0, RST_B = 0, TLP_VALID = 0, TLP_SECONDARY = 0, TLP_TO_BRIDGE = 0;
    logic TO_ACKS_DONE = 0, SWITCH_LOW_POWER, TLP_ACCEPT, TLP_UR, TLP_UC, TLP_ROUTE;
    logic [1:0] TLP_PORT = 0;
    bpsc_tlp_kind_type TLP_KIND = BPSC_TLP_CFG0;
    logic [2:0] CFG_DONE, PSF_WR, POWER_REMOVED, ERR_EVENT = 0, ERR_FROM_TLP = 0;
    logic [2:0] NO_SOFT_RESET, L1_REQ, ERR_MSG;
    logic [5:0] PSF_WDATA, PSTATE, PSF_RDATA;
    int bad_count = 0, checks_done = 0;
    always #12.5 CLK_SYS = ~CLK_SYS;
    bpsc_host i_bpsc_host (.CLK_SYS, .CFG_DONE, .PSF_WR, .POWER_REMOVED, .PSF_WDATA);
    bpsc_bridge_power i_bpsc_bridge_power (.CLK_SYS, .RST_B, .CFG_DONE, .PSF_WR, .PSF_WDATA,
        .POWER_REMOVED, .TLP_VALID, .TLP_PORT, .TLP_KIND, .TLP_SECONDARY, .TLP_TO_BRIDGE,
        .ERR_EVENT, .ERR_FROM_TLP, .TO_ACKS_DONE, .PSTATE, .PSF_RDATA, .NO_SOFT_RESET,
        .L1_REQ, .SWITCH_LOW_POWER, .TLP_ACCEPT, .TLP_UR, .TLP_UC, .TLP_ROUTE, .ERR_MSG);
    task automatic results;
        $display("mismatches %0d checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tlp(input bpsc_tlp_kind_type k, input logic s, b, input logic [3:0] e);
        @(posedge CLK_SYS);
        TLP_VALID <= 1;
        TLP_KIND <= k;
        TLP_SECONDARY <= s;
        TLP_TO_BRIDGE <= b;
        @(posedge CLK_SYS);
        TLP_VALID <= 0;
        #1 `CHK({TLP_ACCEPT, TLP_UR, TLP_UC, TLP_ROUTE}, e)
    endtask
    task automatic err(input logic f, e);
        @(posedge CLK_SYS);
        ERR_EVENT <= 3'h1;
        ERR_FROM_TLP <= {2'h0, f};
        @(posedge CLK_SYS);
        ERR_EVENT <= 0;
        #1 `CHK(ERR_MSG, {2'h0, e})
    endtask
    task automatic t_enter_d3;
        i_bpsc_host.ev(3'h1, 3'h0, 3'h0, 6'h3F);
        #1 `CHK(PSTATE, 6'h01)
        i_bpsc_host.ev(3'h0, 3'h1, 3'h0, 6'h01);
        #1 `CHK(PSTATE, 6'h01)
        // all fields written, only bridge 0 strobed
        i_bpsc_host.ev(3'h0, 3'h1, 3'h0, 6'h3F);
        #1 `CHK({PSF_RDATA, L1_REQ, PSTATE}, 15'h0642)
    endtask
    task automatic t_d3_traffic;
        tlp(BPSC_TLP_CFG0, 0, 0, 4'h8);
        tlp(BPSC_TLP_MSG, 0, 1, 4'h8);
        tlp(BPSC_TLP_REQ, 0, 0, 4'h4);
        tlp(BPSC_TLP_CPL, 0, 1, 4'h2);
        tlp(BPSC_TLP_CPL, 1, 0, 4'h1);
        tlp(BPSC_TLP_REQ, 1, 0, 4'h4);
        err(1, 1);
        err(0, 0);
        TLP_PORT <= 2'h1;
        tlp(BPSC_TLP_REQ, 0, 0, 4'h8);
    endtask
    task automatic t_exit;
        @(posedge CLK_SYS);
        TO_ACKS_DONE <= 1;
        @(posedge CLK_SYS);
        #1 `CHK(SWITCH_LOW_POWER, 1'b1)
        i_bpsc_host.ev(3'h0, 3'h1, 3'h0, 6'h00);
        #1 `CHK({L1_REQ, NO_SOFT_RESET, PSTATE}, 12'h1C0)
        i_bpsc_host.ev(3'h1, 3'h0, 3'h0, 6'h00);
        i_bpsc_host.ev(3'h0, 3'h1, 3'h0, 6'h03);
        i_bpsc_host.ev(3'h0, 3'h0, 3'h1, 6'h00);
        #1 `CHK(PSTATE, 6'h03)
    endtask
    // tests need under 100 cycles; generous margin
    initial begin
        #20us;
        bad_count++;
        results;
    end
    initial begin
        repeat (5) @(posedge CLK_SYS);
        RST_B <= 1;
        t_enter_d3;
        t_d3_traffic;
        t_exit;
        results;
    end
endmodule

// ---- design/bpsc_bridge_power.sv ----
/*
 Per-port power state tracking for the bridges of a switch, with TLP
 disposition while a bridge is in D3hot, L1 request per link and
 whole-switch low-power entry. Assumes a single core clock, synchronous
 inputs, and that configuration and power-state writes arrive as
 one-cycle strobes from the configuration space logic. Port 0 is upstream.
*/
`timescale 1ns/1ps
`include "bpsc_consts.svh"

// Contract
// - each bridge holds its own power state
// - D3hot permits that link to enter L1
// - L1 attempt ignores other ports' states
// - upstream low power plus acks: switch low
// - four states: D0 uninit, active, D3hot, D3cold
// - reset gives D0 uninit; configuration gives active
// - D0 active plus D3hot write gives D3hot
// - D3hot plus D0 write gives D0 uninit
// - leaving D3hot resets no logic or registers
// - no-soft-reset flag defaults to context kept
// - D3hot completes type 0 configuration requests
// - D3hot accepts messages targeting the bridge
// - D3hot: other primary requests are UR
// - D3hot: TLP-caused errors reported as D0
// - D3hot: non-TLP errors are dropped
// - D3hot: completions to bridge are UC
// - D3hot: passing completions routed as D0
// - D3hot: secondary requests are UR
module bpsc_bridge_power #(
    parameter int NPORTS = `BPSC_NUM_PORTS
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // configuration events, one bit per bridge; PSF_WDATA two bits per bridge
    input wire logic [NPORTS-1:0] CFG_DONE,
    input wire logic [NPORTS-1:0] PSF_WR,
    input wire logic [2*NPORTS-1:0] PSF_WDATA,
    input wire logic [NPORTS-1:0] POWER_REMOVED,
    // received tlp to classify
    input wire logic TLP_VALID,
    input wire logic [1:0] TLP_PORT,
    input wire bpsc_pkg::bpsc_tlp_kind_type TLP_KIND,
    input wire logic TLP_SECONDARY,
    input wire logic TLP_TO_BRIDGE,
    // error events to filter
    input wire logic [NPORTS-1:0] ERR_EVENT,
    input wire logic [NPORTS-1:0] ERR_FROM_TLP,
    // upstream turn-off handshake
    input wire logic TO_ACKS_DONE,
    // state outputs
    output logic [2*NPORTS-1:0] PSTATE,
    output logic [2*NPORTS-1:0] PSF_RDATA,
    output logic [NPORTS-1:0] NO_SOFT_RESET,
    output logic [NPORTS-1:0] L1_REQ,
    output logic SWITCH_LOW_POWER,
    // tlp disposition, one cycle after TLP_VALID
    output logic TLP_ACCEPT,
    output logic TLP_UR,
    output logic TLP_UC,
    output logic TLP_ROUTE,
    // filtered error message request
    output logic [NPORTS-1:0] ERR_MSG
);
    import bpsc_pkg::*;

    bpsc_pstate_type pstate [NPORTS];
    bpsc_pstate_type next_pstate [NPORTS];
    logic [1:0] psf [NPORTS];
    logic [NPORTS-1:0] in_d3hot;

    function automatic bpsc_pstate_type step(input bpsc_pstate_type cur,
                                             input logic cfg,
                                             input logic wr,
                                             input logic [1:0] wdata,
                                             input logic off);
        bpsc_pstate_type nxt;
        nxt = cur;
        case (cur)
            BPSC_D0_UNINIT: begin
                if (cfg) begin
                    nxt = BPSC_D0_ACTIVE;
                end
            end
            BPSC_D0_ACTIVE: begin
                if (wr && wdata == `BPSC_PSF_D3HOT) begin
                    nxt = BPSC_D3_HOT;
                end
            end
            BPSC_D3_HOT: begin
                if (off) begin
                    nxt = BPSC_D3_COLD;
                end else if (wr && wdata == `BPSC_PSF_D0) begin
                    nxt = BPSC_D0_UNINIT;
                end
            end
            BPSC_D3_COLD: begin
                nxt = BPSC_D3_COLD; // left only by fundamental reset
            end
            default: begin
                nxt = BPSC_D0_UNINIT;
            end
        endcase
        return nxt;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NPORTS; g++) begin : port
            // each bridge has its own state, nothing shared
            assign next_pstate[g] = step(pstate[g], CFG_DONE[g], PSF_WR[g],
                                         PSF_WDATA[2*g +: 2], POWER_REMOVED[g]);
            assign in_d3hot[g] = (pstate[g] == BPSC_D3_HOT);
            // per-port only, no term from other ports
            assign L1_REQ[g] = in_d3hot[g];
            assign PSTATE[2*g +: 2] = pstate[g];
            assign PSF_RDATA[2*g +: 2] = psf[g];
            assign NO_SOFT_RESET[g] = `BPSC_NSR_RESET;
            // only state moves; no other register is touched
            always_ff @(posedge CLK_SYS or negedge RST_B) begin
                if (!RST_B) begin
                    pstate[g] <= BPSC_D0_UNINIT;
                end else begin
                    pstate[g] <= next_pstate[g];
                end
            end
            // field mirrors last legal encoding written; others ignored
            always_ff @(posedge CLK_SYS or negedge RST_B) begin
                if (!RST_B) begin
                    psf[g] <= `BPSC_PSF_D0;
                end else if (PSF_WR[g] && (PSF_WDATA[2*g +: 2] == `BPSC_PSF_D0 ||
                             PSF_WDATA[2*g +: 2] == `BPSC_PSF_D3HOT)) begin
                    psf[g] <= PSF_WDATA[2*g +: 2];
                end
            end
        end
    endgenerate

    // errors: tlp-caused pass always, others dropped in D3hot
    logic [NPORTS-1:0] next_err_msg;
    assign next_err_msg = ERR_EVENT & (ERR_FROM_TLP | ~in_d3hot);

    // upstream port governs the whole switch
    wire up_low = (pstate[0] == BPSC_D3_HOT) || (pstate[0] == BPSC_D3_COLD);
    wire next_low = up_low && TO_ACKS_DONE;

    // tlp disposition
    wire port_ok = (32'(TLP_PORT) < NPORTS);
    wire tgt_d3 = port_ok && in_d3hot[TLP_PORT];
    wire is_cpl = (TLP_KIND == BPSC_TLP_CPL);
    wire keep_cfg = (TLP_KIND == BPSC_TLP_CFG0) && !TLP_SECONDARY;
    wire keep_msg = (TLP_KIND == BPSC_TLP_MSG) && TLP_TO_BRIDGE && !TLP_SECONDARY;
    // secondary requests all refused; primary cfg0 and bridge messages kept
    wire d3_ur = tgt_d3 && !is_cpl && !keep_cfg && !keep_msg;
    wire d3_uc = tgt_d3 && is_cpl && TLP_TO_BRIDGE;
    // completions through the bridge route as in D0
    wire next_route = TLP_VALID && is_cpl && !TLP_TO_BRIDGE;
    wire next_ur = TLP_VALID && d3_ur;
    wire next_uc = TLP_VALID && d3_uc;
    wire next_accept = TLP_VALID && !d3_ur && !d3_uc && !next_route;

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            TLP_ACCEPT <= 1'h0;
            TLP_UR <= 1'h0;
            TLP_UC <= 1'h0;
            TLP_ROUTE <= 1'h0;
            ERR_MSG <= '0;
            SWITCH_LOW_POWER <= 1'h0;
        end else begin
            TLP_ACCEPT <= next_accept;
            TLP_UR <= next_ur;
            TLP_UC <= next_uc;
            TLP_ROUTE <= next_route;
            ERR_MSG <= next_err_msg;
            SWITCH_LOW_POWER <= next_low;
        end
    end
endmodule

// ---- design/bpsc_consts.svh ----
/*
 Constants for the bridge power state control block: power-state field
 encodings, reset values and port count. Assumes nothing; definitions only.
*/
`ifndef BPSC_CONSTS_SVH
`define BPSC_CONSTS_SVH

`define BPSC_PSF_D0 2'h0
`define BPSC_PSF_D3HOT 2'h3
`define BPSC_NUM_PORTS 3
`define BPSC_NSR_RESET 1'h1

`endif

// ---- design/bpsc_pkg.sv ----
/*
 Types for the bridge power state control block.
 Assumes the constants header is available on the include path.
*/
package bpsc_pkg;
    typedef enum logic [1:0] {
        BPSC_D0_UNINIT,
        BPSC_D0_ACTIVE,
        BPSC_D3_HOT,
        BPSC_D3_COLD
    } bpsc_pstate_type;

    typedef enum logic [1:0] {
        BPSC_TLP_CFG0,
        BPSC_TLP_MSG,
        BPSC_TLP_REQ,
        BPSC_TLP_CPL
    } bpsc_tlp_kind_type;
endpackage
